/* rtl/smx_scan_port.sv */
`timescale 1ns/1ps
// Function
// - Route 32 channels and sensor, one at a time.
// - Scan clock rising edge steps the multiplexer.
// - Module drives serial output line with its data.
// - Select line marks address or data bits.
// - Each path filtered, multiplexed out, then amplified.
// - Per-channel gain 1 or 100, applied when scanned.
module smx_scan_port
#(
    parameter int NUM_CH = smx_pkg::NUM_CHANNELS
)
(
    input  wire logic              core_clk,
    input  wire logic              rstn,
    input  wire logic              scan_advance_clock,
    input  wire logic              serial_shift_clock,
    input  wire logic              serial_input_line,
    input  wire logic              data_or_address_select,
    input  wire logic              controller_slot_select_n,
    output logic                   serial_output_line,
    output logic [NUM_CH-1:0]      channel_select_onehot,
    output logic                   cold_junction_select,
    output logic                   gain_100_select,
    output logic [smx_pkg::SEL_W-1:0] mux_index
);
    // =========================================================================
    // Synchronised link lines.
    // =========================================================================
    smx_edge_if edges ();   // Edges and levels from the link.
    // The link lines all cross into core_clk here; nothing else reads the pins.
    smx_link_sync u_sync
    (
        .core_clk                 (core_clk),
        .rstn                     (rstn),
        .scan_advance_clock       (scan_advance_clock),
        .serial_shift_clock       (serial_shift_clock),
        .serial_input_line        (serial_input_line),
        .data_or_address_select   (data_or_address_select),
        .controller_slot_select_n (controller_slot_select_n),
        .edges                    (edges)
    );
    // =========================================================================
    // State.
    // =========================================================================
    typedef struct packed
    {
        logic [smx_pkg::SEL_W-1:0]  sel;       // Present scan slot.
        logic [NUM_CH-1:0]          gain;      // One gain bit per channel.
        logic [smx_pkg::WORD_W-1:0] shift_in;  // Incoming bits.
        logic [smx_pkg::WORD_W-1:0] shift_out; // Outgoing bits.
        logic [2:0]                 bit_cnt;   // Bits taken in the word.
        logic                       addressed; // This module was addressed.
        logic [smx_pkg::WORD_W-1:0] cmd;       // Last command word.
        logic                       have_cmd;  // Command awaits its data word.
        logic                       miso;      // Serial output bit.
    } smx_core_s;
    smx_core_s st_q;        // Registered state.
    smx_core_s st_d;        // Next state.
    logic [smx_pkg::WORD_W-1:0] word_next;     // Word with the bit just taken.
    logic [1:0]                 gain_grp;      // Gain byte addressed by a command.
    // Next state for scanning and the serial port.
    always_comb
    begin
        st_d      = st_q;
        word_next = {st_q.shift_in[smx_pkg::WORD_W-2:0], edges.mosi};
        gain_grp  = st_q.cmd[1:0];
        // Step the multiplexer after each sample, wrapping after the sensor.
        if (edges.scan_rise)
        begin
            if (st_q.sel == smx_pkg::SEL_LAST)
            begin
                st_d.sel = smx_pkg::SEL_RESET;
            end
            else
            begin
                st_d.sel = st_q.sel + 6'h01;
            end
        end
        // Traffic meant for slot 0 is ignored and restarts word framing.
        if (!edges.slot_sel_n)
        begin
            st_d.bit_cnt = smx_pkg::BIT_CNT_RESET;
        end
        else if (edges.sclk_rise)
        begin
            st_d.shift_in = word_next;
            st_d.bit_cnt  = st_q.bit_cnt + 3'h1;
            if (st_q.bit_cnt == 3'h7)
            begin
                // A full word: address words pick the module, data words act.
                if (!edges.da_sel)
                begin
                    st_d.addressed = (word_next == smx_pkg::MODULE_ADDR);
                    st_d.have_cmd  = 1'b0;
                end
                else if (st_q.addressed && !st_q.have_cmd)
                begin
                    st_d.cmd      = word_next;
                    st_d.have_cmd = (word_next <= smx_pkg::CMD_GAIN_LAST);
                    if (word_next == smx_pkg::CMD_SEL_READ)
                    begin
                        st_d.shift_out = {2'h0, st_q.sel};
                    end
                end
                else if (st_q.addressed)
                begin
                    // Data word stores eight channel gains.
                    st_d.gain[gain_grp*8 +: 8] = word_next;
                    st_d.have_cmd              = 1'b0;
                end
            end
        end
        // Drive the next outgoing bit on the falling edge.
        if (edges.slot_sel_n && edges.sclk_fall && st_q.addressed)
        begin
            st_d.miso      = st_q.shift_out[smx_pkg::WORD_W-1];
            st_d.shift_out = {st_q.shift_out[smx_pkg::WORD_W-2:0], 1'b0};
        end
    end
    // Register the state.
    always_ff @(posedge core_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            st_q <= '{sel: smx_pkg::SEL_RESET, gain: smx_pkg::GAIN_RESET,
                      shift_in: 8'h00, shift_out: 8'h00,
                      bit_cnt: smx_pkg::BIT_CNT_RESET, addressed: 1'b0,
                      cmd: 8'h00, have_cmd: 1'b0, miso: 1'b0};
        end
        else
        begin
            st_q <= st_d;
        end
    end
    // =========================================================================
    // Analog switch controls, one select per channel path.
    // =========================================================================
    genvar gi;
    generate
        for (gi = 0; gi < NUM_CH; gi++)
        begin : g_sel
            // Each path's switch closes only in its own slot.
            assign channel_select_onehot[gi] = (st_q.sel == 6'(gi));
        end
    endgenerate
    assign cold_junction_select = (st_q.sel == smx_pkg::SEL_CJ);
    // Gain of the channel in the scan slot; the sensor always uses gain 1.
    assign gain_100_select = (st_q.sel[5] == 1'b0) && st_q.gain[st_q.sel[4:0]];
    assign mux_index          = st_q.sel;
    assign serial_output_line = st_q.miso;
endmodule // smx_scan_port

/* inc/smx_pkg.sv */
package smx_pkg;
    // =========================================================================
    // Scan sequence layout.
    // =========================================================================
    localparam int          NUM_CHANNELS   = 32;           // Input channel paths.
    localparam int          SEL_W          = 6;            // Selector width.
    localparam logic [5:0]  SEL_CJ         = 6'h20;        // Cold-junction slot.
    localparam logic [5:0]  SEL_RESET      = 6'h00;        // Selector after reset.
    localparam logic [5:0]  SEL_LAST       = 6'h20;        // Last slot of the scan.
    // =========================================================================
    // Serial word layout.
    // =========================================================================
    localparam int          WORD_W         = 8;            // Bits per serial word.
    localparam logic [7:0]  MODULE_ADDR    = 8'h01;        // Our address, arbitrary.
    localparam logic [7:0]  CMD_GAIN_LO    = 8'h00;        // Gains of channels 0..7.
    localparam logic [7:0]  CMD_GAIN_LAST  = 8'h03;        // Gains of channels 24..31.
    localparam logic [7:0]  CMD_SEL_READ   = 8'h04;        // Load selector for readback.
    localparam logic [31:0] GAIN_RESET     = 32'h00000000; // All channels at gain 1.
    localparam logic [2:0]  BIT_CNT_RESET  = 3'h0;         // Bit counter after reset.
    // Gain codes for one channel.
    typedef enum logic
    {
        SMX_GAIN_1,
        SMX_GAIN_100
    } smx_gain_e;
endpackage

/* inc/smx_edge_if.sv */
`timescale 1ns/1ps
// Carries synchronised levels and edge pulses of the link lines.
interface smx_edge_if;
    logic scan_rise;    // Scan advance clock rose.
    logic sclk_rise;    // Serial clock rose.
    logic sclk_fall;    // Serial clock fell.
    logic mosi;         // Synchronised serial input.
    logic da_sel;       // Synchronised data/address select.
    logic slot_sel_n;   // Synchronised controller slot select.
    modport sync (output scan_rise, output sclk_rise, output sclk_fall,
                  output mosi, output da_sel, output slot_sel_n);
    modport core (input scan_rise, input sclk_rise, input sclk_fall,
                  input mosi, input da_sel, input slot_sel_n);
endinterface

/* rtl/smx_link_sync.sv */
`timescale 1ns/1ps
// Two-stage synchronisers for the link lines, plus edge finders on the clocks.
module smx_link_sync
(
    input  wire logic core_clk,
    input  wire logic rstn,
    input  wire logic scan_advance_clock,
    input  wire logic serial_shift_clock,
    input  wire logic serial_input_line,
    input  wire logic data_or_address_select,
    input  wire logic controller_slot_select_n,
    smx_edge_if.sync  edges
);
    // =========================================================================
    // State.
    // =========================================================================
    typedef struct packed
    {
        logic [4:0] s1;     // First stage, read only by the second stage.
        logic [4:0] s2;     // Second stage, safe to use.
        logic [1:0] prev;   // Previous second-stage value of both clocks.
    } smx_sync_s;
    smx_sync_s st_q;        // Registered state.
    smx_sync_s st_d;        // Next state.
    // Next state: shift the pins through both stages.
    always_comb
    begin
        st_d      = st_q;
        st_d.s1   = {controller_slot_select_n, data_or_address_select,
                     serial_input_line, serial_shift_clock, scan_advance_clock};
        st_d.s2   = st_q.s1;
        st_d.prev = st_q.s2[1:0];
    end
    // Register the state; slot select idles high.
    always_ff @(posedge core_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            st_q <= '{s1: 5'h10, s2: 5'h10, prev: 2'h0};
        end
        else
        begin
            st_q <= st_d;
        end
    end
    // Edge pulses and levels from the second stage only.
    assign edges.scan_rise  = st_q.s2[0] & ~st_q.prev[0];
    assign edges.sclk_rise  = st_q.s2[1] & ~st_q.prev[1];
    assign edges.sclk_fall  = ~st_q.s2[1] & st_q.prev[1];
    assign edges.mosi       = st_q.s2[2];
    assign edges.da_sel     = st_q.s2[3];
    assign edges.slot_sel_n = st_q.s2[4];
endmodule // smx_link_sync

/* verif/smx_scan_port_props.sv */
`timescale 1ns/1ps
// ========================================
// Checks on the scan port outputs.
module smx_scan_port_props
#(
    parameter int NUM_CH = 32
)
(
    input wire logic              core_clk,
    input wire logic              rstn,
    input wire logic              scan_advance_clock,
    input wire logic              serial_shift_clock,
    input wire logic              serial_input_line,
    input wire logic              data_or_address_select,
    input wire logic              controller_slot_select_n,
    input wire logic              serial_output_line,
    input wire logic [NUM_CH-1:0] channel_select_onehot,
    input wire logic              cold_junction_select,
    input wire logic              gain_100_select,
    input wire logic [5:0]        mux_index
);
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!rstn);
    // A scan edge as the core clock first sees it.
    sequence s_scan_edge;
        $rose(scan_advance_clock);
    endsequence
    // The slot moves once the edge has crossed the synchronisers.
    sequence s_slot_moves;
        ##[2:6] $changed(mux_index);
    endsequence
    a_scan_steps: assert property (s_scan_edge |-> s_slot_moves)
        else $error("scan edge did not move the slot");
    a_step_value: assert property ($changed(mux_index) |->
        mux_index == (($past(mux_index) == 6'h20) ? 6'h00 : $past(mux_index) + 6'h01))
        else $error("slot did not step by one");
    a_onehot_slot: assert property (mux_index < 6'h20 |->
        channel_select_onehot == ({{(NUM_CH-1){1'b0}}, 1'b1} << mux_index))
        else $error("channel select does not match slot");
    a_cj_slot: assert property (cold_junction_select == (mux_index == 6'h20))
        else $error("sensor select does not match slot");
    a_cj_gain: assert property (cold_junction_select |->
        !gain_100_select && channel_select_onehot == '0)
        else $error("sensor slot has gain or channel");
    a_gain_cause: assert property ($changed(gain_100_select) && $stable(mux_index) |->
        $past(data_or_address_select, 3))
        else $error("gain changed without a data word");
    a_miso_shift: assert property ($changed(serial_output_line) |->
        $past(serial_shift_clock, 5) && !$past(serial_shift_clock, 2))
        else $error("output line changed away from a falling edge");
endmodule // smx_scan_port_props
bind smx_scan_port smx_scan_port_props #(.NUM_CH(NUM_CH)) u_props (.core_clk, .rstn,
    .scan_advance_clock, .serial_shift_clock, .serial_input_line, .data_or_address_select,
    .controller_slot_select_n, .serial_output_line, .channel_select_onehot,
    .cold_junction_select, .gain_100_select, .mux_index);

/* verif/smx_ctl_model.sv */
`timescale 1ns/1ps
// ========================================
// Acquisition controller model; it drives the link lines, though the bench also sets its slot select.
module smx_ctl_model
(
    input  wire logic core_clk,
    output logic      scan_advance_clock,
    output logic      serial_shift_clock,
    output logic      serial_input_line,
    output logic      data_or_address_select,
    output logic      controller_slot_select_n,
    input  wire logic serial_output_line
);
    // Idle levels; the serial clock stands low outside words.
    initial
    begin
        scan_advance_clock = 1'b0;
        serial_shift_clock = 1'b0;
        serial_input_line = 1'b0;
        data_or_address_select = 1'b0;
        controller_slot_select_n = 1'b1;
    end
    // One half period of the 160 ns serial clock.
    task automatic half;
        repeat (4) @(negedge core_clk);
    endtask
    // Raises the scan clock after a sample, then lets the slot settle.
    task automatic scan_pulse;
        @(negedge core_clk);
        scan_advance_clock = 1'b1;
        repeat (4) @(negedge core_clk);
        scan_advance_clock = 1'b0;
        repeat (6) @(negedge core_clk);
    endtask
    // Moves one word, MSB first: change on fall, sample on rise.
    task automatic xfer(input logic da, input logic [7:0] tx, output logic [7:0] rx);
        data_or_address_select = da;
        for (int b = 7; b >= 0; b--)
        begin
            serial_input_line = tx[b];
            half();
            serial_shift_clock = 1'b1;
            rx[b] = serial_output_line;
            half();
            serial_shift_clock = 1'b0;
        end
        serial_input_line = ~tx[0];
        half();
    endtask
endmodule // smx_ctl_model

/* verif/smx_scan_port_tb.sv */
`timescale 1ns/1ps
// ========================================
// Bench for the scan port, driven through the controller model.
module smx_scan_port_tb;
    logic core_clk = 1'b0;
    logic rstn = 1'b0;
    logic scan_advance_clock, serial_shift_clock, serial_input_line, serial_output_line;
    logic data_or_address_select, controller_slot_select_n;
    logic [31:0] channel_select_onehot;
    logic cold_junction_select, gain_100_select;
    logic [5:0] mux_index;
    logic [31:0] gains; // Expected gain bit of each channel.
    logic [7:0] rx;     // Byte read back from the module.
    int error_cnt = 0;
    int compares = 0;
    always #10 core_clk = ~core_clk;
    smx_ctl_model u_ctl (.core_clk, .scan_advance_clock, .serial_shift_clock,
        .serial_input_line, .data_or_address_select, .controller_slot_select_n,
        .serial_output_line);
    smx_scan_port #(.NUM_CH(32)) u_dut (.core_clk, .rstn, .scan_advance_clock,
        .serial_shift_clock, .serial_input_line, .data_or_address_select,
        .controller_slot_select_n, .serial_output_line, .channel_select_onehot,
        .cold_junction_select, .gain_100_select, .mux_index);
    // Counts a comparison and reports a mismatch.
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic give_verdict;
        $display("compares=%0d error_cnt=%0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    // Steps through every slot, wrapping to 0, checking select and gain.
    task automatic t_walk;
        int s;
        for (int i = 1; i <= 33; i++)
        begin
            s = i % 33;
            u_ctl.scan_pulse();
            chk(mux_index, s);
            chk(channel_select_onehot, (s < 32) ? 32'h1 << s : 32'h0);
            chk(cold_junction_select, s == 32);
            chk(gain_100_select, (s < 32) ? gains[s] : 1'b0);
        end
        $display("walk done");
    endtask
    // Address word, then command and data words.
    task automatic put(input logic [7:0] adr, input logic [7:0] cmd, input logic [7:0] dat);
        u_ctl.xfer(1'b0, adr, rx);
        u_ctl.xfer(1'b1, cmd, rx);
        u_ctl.xfer(1'b1, dat, rx);
    endtask
    // Writes all four gain groups.
    task automatic t_gain;
        for (int k = 0; k < 4; k++)
        begin
            put(smx_pkg::MODULE_ADDR, k[7:0], 8'hA5 + k[7:0]);
            gains[8*k +: 8] = 8'hA5 + k[7:0];
        end
        t_walk();
    endtask
    // Slot-0 traffic and a foreign address leave the gains alone.
    task automatic t_refused;
        u_ctl.controller_slot_select_n = 1'b0;
        put(smx_pkg::MODULE_ADDR, 8'h00, 8'h00);
        u_ctl.controller_slot_select_n = 1'b1;
        put(8'h02, 8'h00, 8'h00);
        t_walk();
    endtask
    // Reads the slot number back on the output line.
    task automatic t_read;
        repeat (5) u_ctl.scan_pulse();
        u_ctl.xfer(1'b0, smx_pkg::MODULE_ADDR, rx);
        u_ctl.xfer(1'b1, smx_pkg::CMD_SEL_READ, rx);
        u_ctl.xfer(1'b1, 8'h00, rx);
        chk(rx, 8'h05);
        $display("read done");
    endtask
    initial
    begin
        gains = smx_pkg::GAIN_RESET;
        repeat (6) @(negedge core_clk);
        rstn = 1'b1;
        repeat (6) @(negedge core_clk);
        chk(channel_select_onehot, 32'h1);
        t_walk();
        t_gain();
        t_refused();
        t_read();
        give_verdict();
    end
    // Cuts a hang short.
    initial
    begin
        #500us;
        error_cnt++;
        give_verdict();
    end
endmodule // smx_scan_port_tb
